/* core/lock_regs_consts.svh */
// Register indices, field positions and reset values of the lock/sync bank
`ifndef LOCK_REGS_CONSTS_SVH
`define LOCK_REGS_CONSTS_SVH

`define IDX_LOCK_TYPE        8'h3B
`define IDX_LOCK_DELAY       8'h3C
`define IDX_RSVD_A           8'h3D
`define IDX_RSVD_B           8'h3E
`define IDX_RSVD_C           8'h3F
`define IDX_RSVD_D           8'h40
`define IDX_RSVD_E           8'h41
`define IDX_RSVD_F           8'h42
`define IDX_RSVD_G           8'h43
`define IDX_RSVD_H           8'h44
`define IDX_SETTLE_HIGH      8'h45
`define IDX_SETTLE_LOW       8'h46
`define IDX_ALIGN_CTRL       8'h47
`define IDX_IRQ_STATUS       8'h50
`define IDX_IRQ_MASK         8'h51
`define IDX_BURST_COUNT      8'h52

`define BANK_FIRST           8'h3B
`define BANK_WORDS           13

`define RST_LOCK_TYPE        16'h0001
`define RST_LOCK_DELAY       16'h03E8
`define RST_RSVD_A           16'h00A8
`define RST_RSVD_B           16'h00AE
`define RST_RSVD_C           16'h0000
`define RST_RSVD_D           16'h1388
`define RST_RSVD_E           16'h0000
`define RST_RSVD_F           16'h0140
`define RST_RSVD_G           16'h0000
`define RST_RSVD_H           16'h03E8
`define RST_SETTLE_HIGH      16'h0000
`define RST_SETTLE_LOW       16'hC350
`define RST_ALIGN_CTRL       16'h0080
`define RST_BURST_COUNT      4'h0

`define BIT_LOCK_SELECT      0
`define BIT_REPEATER         2
`define BIT_ALIGN_ENABLE     3
`define BIT_BURST_ENABLE     4
`define PRESCALER_LSB        5
`define PRESCALER_MSB        7
`define PRESCALE_DIV2        3'h2
`define PRESCALE_DIV4        3'h4

`define IRQ_LOCK_RISE        0
`define IRQ_LOCK_FALL        1
`define IRQ_SETTLE_DONE      2
`define IRQ_BURST_DONE       3
`define IRQ_BITS             4

`endif

/* core/lock_regs_pkg.sv */
// Types shared by the lock/sync register bank
package lock_regs_pkg;
    typedef logic [15:0] reg_word_t;
    typedef enum logic [1:0] {
        align_idle,
        align_run,
        align_burst
    } align_state_e;
endpackage : lock_regs_pkg

/* core/settle_counter.sv */
// Settle delay down-counter for phase synchronization
module settle_counter #(
    parameter int WIDTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             tick,
    output logic                  busy,
    output logic                  done
);
    logic [WIDTH-1:0] count;

    if (WIDTH < 2) begin : g_check
        $error("settle_counter WIDTH must be at least 2");
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            count <= '0;
            busy  <= 1'b0;
        end else if (load) begin
            count <= load_value;
            busy  <= (load_value != '0);
        end else if (busy && tick) begin
            count <= count - 1'b1;
            busy  <= (count != {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge mclk) begin
        if (reset)
            done <= 1'b0;
        else
            done <= busy && tick && !load
                    && (count == {{(WIDTH-1){1'b0}}, 1'b1});
    end
endmodule : settle_counter

/* core/lock_detect_sync_delay_regs.sv */
// Lock indicator, sync settle delay and alignment pulse register bank
// Functional notes
// - lock select bit 0 at 0x3B picks cal-only or cal+tuning lock; resets 1.
// - Cal-only lock rises after calibration ends and the delay count expires.
// - Cal+tuning lock also needs tuning voltage within its window.
// - Lock delay counts quarter periods of the phase detector clock.
// - Settle count upper half at 0x45, lower at 0x46, lower resets 0xC350.
// - Sync inserts settle count periods of the state-machine clock.
// - Prescaler bits 7:5 at 0x47 divide by 2 or 4; resets to 4.
// - Master mode sends alignment pulses continuously.
// - Repeater mode sends alignment pulses only on request pin.
// - Master with burst enable sends a counted burst on request rise.
//
// The Wishbone register port was decided locally.
`include "lock_regs_consts.svh"

module lock_detect_sync_delay_regs #(
    parameter int DELAY_WIDTH  = 16,
    parameter int SETTLE_WIDTH = 32
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    // Wishbone classic slave
    input  wire logic [9:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    // Synthesizer side
    input  wire logic        cal_busy,
    input  wire logic        pd_quarter_tick,
    input  wire logic        vtune_in_window,
    input  wire logic        sync_start,
    input  wire logic        sm_clock_tick,
    input  wire logic        interp_tick,
    input  wire logic        alignment_request_pin,
    output logic             lock_indicator,
    output logic             settle_busy,
    output logic             alignment_pulse,
    output logic             irq
);
    lock_regs_pkg::reg_word_t   bank [0:`BANK_WORDS-1];
    lock_regs_pkg::align_state_e state;
    logic [`IRQ_BITS-1:0]        irq_status;
    logic [`IRQ_BITS-1:0]        irq_mask;
    logic [`IRQ_BITS-1:0]        irq_events;
    logic [3:0]                  burst_pulse_count;
    logic [7:0]                  index;
    logic                        bus_req;
    logic                        wr_fire;
    logic [DELAY_WIDTH-1:0]      lock_delay_cnt;
    logic                        cal_busy_q;
    logic                        cal_done_seen;
    logic                        cal_lock;
    logic                        next_lock;
    logic                        settle_done;
    logic [1:0]                  prescale_cnt;
    logic                        prescaled_tick;
    logic                        request_q;
    logic                        request_rise;
    logic [3:0]                  burst_left;
    logic                        burst_done;
    logic [31:0]                 read_word;
    lock_regs_pkg::reg_word_t    align_ctrl;
    logic                        lock_select;
    logic [SETTLE_WIDTH-1:0]     settle_value;

    if (DELAY_WIDTH != 16 || SETTLE_WIDTH != 32) begin : g_check
        $error("lock bank needs DELAY_WIDTH 16 and SETTLE_WIDTH 32");
    end

    function automatic lock_regs_pkg::reg_word_t reset_value(input int i);
        case (i)
            0:       reset_value = `RST_LOCK_TYPE;
            1:       reset_value = `RST_LOCK_DELAY;
            2:       reset_value = `RST_RSVD_A;
            3:       reset_value = `RST_RSVD_B;
            4:       reset_value = `RST_RSVD_C;
            5:       reset_value = `RST_RSVD_D;
            6:       reset_value = `RST_RSVD_E;
            7:       reset_value = `RST_RSVD_F;
            8:       reset_value = `RST_RSVD_G;
            9:       reset_value = `RST_RSVD_H;
            10:      reset_value = `RST_SETTLE_HIGH;
            11:      reset_value = `RST_SETTLE_LOW;
            12:      reset_value = `RST_ALIGN_CTRL;
            default: reset_value = 16'h0000;
        endcase
    endfunction : reset_value

    // Byte lanes 0 and 1 carry the 16-bit word; upper lanes are ignored
    function automatic lock_regs_pkg::reg_word_t merge(
        input lock_regs_pkg::reg_word_t old_value,
        input logic [31:0]              new_value,
        input logic [3:0]               lanes
    );
        merge = old_value;
        if (lanes[0])
            merge[7:0] = new_value[7:0];
        if (lanes[1])
            merge[15:8] = new_value[15:8];
    endfunction : merge

    function automatic logic in_bank(input logic [7:0] idx);
        in_bank = (idx >= `BANK_FIRST) && (idx <= `IDX_ALIGN_CTRL);
    endfunction : in_bank

    function automatic logic [3:0] bank_slot(input logic [7:0] idx);
        logic [7:0] offset;
        offset    = idx - `BANK_FIRST;
        bank_slot = offset[3:0];
    endfunction : bank_slot

    function automatic lock_regs_pkg::reg_word_t field(input logic [7:0] idx);
        field = bank[bank_slot(idx)];
    endfunction : field

    assign index   = adr_i[9:2];
    assign bus_req = cyc_i && stb_i;
    // Writes land on the edge where the master sees ack
    assign wr_fire = bus_req && we_i && ack_o;
    assign align_ctrl   = bank[bank_slot(`IDX_ALIGN_CTRL)];
    assign lock_select  = bank[bank_slot(`IDX_LOCK_TYPE)][`BIT_LOCK_SELECT];
    assign settle_value = {bank[bank_slot(`IDX_SETTLE_HIGH)],
                           bank[bank_slot(`IDX_SETTLE_LOW)]};

    // Bus handshake: one wait state, ack drops the cycle after
    always_ff @(posedge mclk) begin
        if (reset)
            ack_o <= 1'b0;
        else
            ack_o <= bus_req && !ack_o;
    end

    always_comb begin
        read_word = 32'h0000_0000;
        if (in_bank(index))
            read_word = {16'h0000, field(index)};
        else if (index == `IDX_IRQ_STATUS)
            read_word = {28'h000_0000, irq_status};
        else if (index == `IDX_IRQ_MASK)
            read_word = {28'h000_0000, irq_mask};
        else if (index == `IDX_BURST_COUNT)
            read_word = {28'h000_0000, burst_pulse_count};
    end

    always_ff @(posedge mclk) begin
        if (reset)
            dat_o <= 32'h0000_0000;
        else if (bus_req && !ack_o)
            dat_o <= read_word;
    end

    // Reserved words keep whatever software writes; values are its duty
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < `BANK_WORDS; i++)
                bank[i] <= reset_value(i);
        end else if (wr_fire && in_bank(index)) begin
            bank[bank_slot(index)] <=
                merge(bank[bank_slot(index)], dat_i, sel_i);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_mask          <= '0;
            burst_pulse_count <= `RST_BURST_COUNT;
        end else if (wr_fire && sel_i[0]) begin
            if (index == `IDX_IRQ_MASK)
                irq_mask <= dat_i[`IRQ_BITS-1:0];
            else if (index == `IDX_BURST_COUNT)
                burst_pulse_count <= dat_i[3:0];
        end
    end

    // Lock delay restarts whenever calibration runs
    always_ff @(posedge mclk) begin
        if (reset)
            lock_delay_cnt <= '0;
        else if (cal_busy)
            lock_delay_cnt <= field(`IDX_LOCK_DELAY);
        else if (lock_delay_cnt != '0 && pd_quarter_tick)
            lock_delay_cnt <= lock_delay_cnt - 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cal_busy_q    <= 1'b0;
            cal_done_seen <= 1'b0;
        end else begin
            cal_busy_q <= cal_busy;
            if (cal_busy)
                cal_done_seen <= 1'b0;
            else if (cal_busy_q)
                cal_done_seen <= 1'b1;
        end
    end

    assign cal_lock = cal_done_seen && !cal_busy
                      && (lock_delay_cnt == '0);

    always_comb begin
        if (lock_select)
            next_lock = cal_lock && vtune_in_window;
        else
            next_lock = cal_lock;
    end

    always_ff @(posedge mclk) begin
        if (reset)
            lock_indicator <= 1'b0;
        else
            lock_indicator <= next_lock;
    end

    settle_counter #(
        .WIDTH(SETTLE_WIDTH)
    ) u_settle (
        .mclk       (mclk),
        .reset      (reset),
        .load       (sync_start),
        .load_value (settle_value),
        .tick       (sm_clock_tick),
        .busy       (settle_busy),
        .done       (settle_done)
    );

    // Prescaler: code 2 divides by 2, any other code by 4
    always_ff @(posedge mclk) begin
        if (reset)
            prescale_cnt <= 2'h0;
        else if (interp_tick)
            prescale_cnt <= prescaled_tick ? 2'h0 : prescale_cnt + 2'h1;
    end

    assign prescaled_tick = interp_tick && (
        (align_ctrl[`PRESCALER_MSB:`PRESCALER_LSB]
            == `PRESCALE_DIV2) ? (prescale_cnt == 2'h1)
                               : (prescale_cnt == 2'h3));

    always_ff @(posedge mclk) begin
        if (reset)
            request_q <= 1'b0;
        else
            request_q <= alignment_request_pin;
    end

    assign request_rise = alignment_request_pin && !request_q;

    // Pulse engine; a burst counts finished pulses on falling edges
    always_ff @(posedge mclk) begin
        if (reset) begin
            state           <= lock_regs_pkg::align_idle;
            alignment_pulse <= 1'b0;
            burst_left      <= 4'h0;
        end else if (!align_ctrl[`BIT_ALIGN_ENABLE]) begin
            state           <= lock_regs_pkg::align_idle;
            alignment_pulse <= 1'b0;
            burst_left      <= 4'h0;
        end else begin
            case (state)
                lock_regs_pkg::align_idle: begin
                    alignment_pulse <= 1'b0;
                    if (align_ctrl[`BIT_REPEATER]) begin
                        if (request_rise) begin
                            burst_left <= 4'h1;
                            state      <= lock_regs_pkg::align_burst;
                        end
                    end else if (align_ctrl[`BIT_BURST_ENABLE]) begin
                        if (request_rise && burst_pulse_count != 4'h0) begin
                            burst_left <= burst_pulse_count;
                            state      <= lock_regs_pkg::align_burst;
                        end
                    end else begin
                        state <= lock_regs_pkg::align_run;
                    end
                end
                lock_regs_pkg::align_run: begin
                    if (align_ctrl[`BIT_REPEATER]
                        || align_ctrl[`BIT_BURST_ENABLE]) begin
                        alignment_pulse <= 1'b0;
                        state           <= lock_regs_pkg::align_idle;
                    end else if (prescaled_tick) begin
                        alignment_pulse <= !alignment_pulse;
                    end
                end
                lock_regs_pkg::align_burst: begin
                    if (prescaled_tick) begin
                        alignment_pulse <= !alignment_pulse;
                        if (alignment_pulse) begin
                            burst_left <= burst_left - 4'h1;
                            if (burst_left == 4'h1)
                                state <= lock_regs_pkg::align_idle;
                        end
                    end
                end
                default: state <= lock_regs_pkg::align_idle;
            endcase
        end
    end

    assign burst_done = (state == lock_regs_pkg::align_burst)
                        && prescaled_tick && alignment_pulse
                        && (burst_left == 4'h1)
                        && align_ctrl[`BIT_ALIGN_ENABLE];

    always_comb begin
        irq_events                   = '0;
        irq_events[`IRQ_LOCK_RISE]   = next_lock && !lock_indicator;
        irq_events[`IRQ_LOCK_FALL]   = !next_lock && lock_indicator;
        irq_events[`IRQ_SETTLE_DONE] = settle_done;
        irq_events[`IRQ_BURST_DONE]  = burst_done;
    end

    // New events win over a write-one-to-clear in the same cycle
    always_ff @(posedge mclk) begin
        if (reset)
            irq_status <= '0;
        else if (wr_fire && sel_i[0] && index == `IDX_IRQ_STATUS)
            irq_status <= (irq_status & ~dat_i[`IRQ_BITS-1:0]) | irq_events;
        else
            irq_status <= irq_status | irq_events;
    end

    assign irq = |(irq_status & irq_mask);
endmodule : lock_detect_sync_delay_regs

/* test/lock_detect_sync_delay_regs_asserts.sv */
// Port-level checks of the lock, settle and alignment register bank
module lock_detect_sync_delay_regs_asserts #(
    parameter int DELAY_WIDTH  = 16,
    parameter int SETTLE_WIDTH = 32
) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [9:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        we_i,
    input wire logic [3:0]  sel_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic        cal_busy,
    input wire logic        pd_quarter_tick,
    input wire logic        vtune_in_window,
    input wire logic        sync_start,
    input wire logic        sm_clock_tick,
    input wire logic        interp_tick,
    input wire logic        alignment_request_pin,
    input wire logic        lock_indicator,
    input wire logic        settle_busy,
    input wire logic        alignment_pulse,
    input wire logic        irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence

    property p_ack_resp;
        s_req |=> s_ack_pulse;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack not one pulse");

    property p_ack_cause;
        $rose(ack_o) |-> $past(cyc_i) && $past(stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");

    property p_reset_out;
        $fell(reset) |-> !ack_o && !irq && !lock_indicator && !settle_busy
            && !alignment_pulse;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not reset");

    property p_lock_cal;
        cal_busy |=> !lock_indicator;
    endproperty
    a_lock_cal: assert property (p_lock_cal) else $error("lock in cal");

    // Even a zero delay needs two quiet cycles after calibration
    property p_lock_rise;
        $rose(lock_indicator) |-> !$past(cal_busy) && !$past(cal_busy, 2);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("early lock");

    property p_settle_rise;
        $rose(settle_busy) |-> $past(sync_start);
    endproperty
    a_settle_rise: assert property (p_settle_rise) else $error("busy");

    property p_settle_hold;
        settle_busy && !sm_clock_tick && !sync_start |=> settle_busy;
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("drop");

    property p_align_rise;
        $rose(alignment_pulse) |-> $past(interp_tick) || $past(interp_tick, 2);
    endproperty
    a_align_rise: assert property (p_align_rise) else $error("pulse");
endmodule : lock_detect_sync_delay_regs_asserts

bind lock_detect_sync_delay_regs lock_detect_sync_delay_regs_asserts #(
    .DELAY_WIDTH(DELAY_WIDTH), .SETTLE_WIDTH(SETTLE_WIDTH)
) chk (
    .mclk(mclk), .reset(reset), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .cal_busy(cal_busy),
    .pd_quarter_tick(pd_quarter_tick), .vtune_in_window(vtune_in_window),
    .sync_start(sync_start), .sm_clock_tick(sm_clock_tick),
    .interp_tick(interp_tick), .alignment_request_pin(alignment_request_pin),
    .lock_indicator(lock_indicator), .settle_busy(settle_busy),
    .alignment_pulse(alignment_pulse), .irq(irq)
);

/* test/lock_detect_sync_delay_regs_tb.sv */
// Self-checking bench for the lock, settle and alignment register bank
module lock_detect_sync_delay_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [7:0]  idx;
        logic [15:0] rst;
        logic [15:0] wr;
        logic [15:0] rb;
    } row_s;
    typedef struct {
        logic [15:0] ctrl;
        logic        req;
        logic [15:0] rises;
    } mode_s;

    logic        mclk, reset, we_i, cyc_i, stb_i, ack_o, irq;
    logic [9:0]  adr_i;
    logic [31:0] dat_i, dat_o;
    logic [3:0]  sel_i;
    logic        cal_busy, pd_quarter_tick, vtune_in_window, sync_start;
    logic        sm_clock_tick, interp_tick, alignment_request_pin;
    logic        lock_indicator, settle_busy, alignment_pulse, prev;
    logic [1:0]  phase;
    logic [15:0] rd, n;
    int          bad_count, compares, cycles;

    // Short lock delay and settle count keep the run brief; 30 is unmapped
    row_s rows [16] = '{
        '{8'h3B, 16'h0001, 16'h0001, 16'h0001},
        '{8'h3C, 16'h03E8, 16'h0003, 16'h0003},
        '{8'h3D, 16'h00A8, 16'h00A8, 16'h00A8},
        '{8'h3E, 16'h00AE, 16'h0322, 16'h0322},
        '{8'h3F, 16'h0000, 16'h0000, 16'h0000},
        '{8'h40, 16'h1388, 16'h1388, 16'h1388},
        '{8'h41, 16'h0000, 16'h0000, 16'h0000},
        '{8'h42, 16'h0140, 16'h01F4, 16'h01F4},
        '{8'h43, 16'h0000, 16'h0000, 16'h0000},
        '{8'h44, 16'h03E8, 16'h03E8, 16'h03E8},
        '{8'h45, 16'h0000, 16'h0000, 16'h0000},
        '{8'h46, 16'hC350, 16'h0010, 16'h0010},
        '{8'h47, 16'h0080, 16'h0080, 16'h0080},
        '{8'h51, 16'h0000, 16'h000F, 16'h000F},
        '{8'h52, 16'h0000, 16'h0003, 16'h0003},
        '{8'h30, 16'h0000, 16'hBEEF, 16'h0000}
    };
    mode_s modes [6] = '{
        '{16'h004C, 1'b0, 16'h0000}, '{16'h004C, 1'b1, 16'h0001},
        '{16'h0048, 1'b0, 16'h0004}, '{16'h0088, 1'b0, 16'h0002},
        '{16'h0058, 1'b1, 16'h0003}, '{16'h0040, 1'b0, 16'h0000}
    };

    lock_detect_sync_delay_regs uut (
        .mclk(mclk), .reset(reset), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .ack_o(ack_o), .cal_busy(cal_busy),
        .pd_quarter_tick(pd_quarter_tick),
        .vtune_in_window(vtune_in_window), .sync_start(sync_start),
        .sm_clock_tick(sm_clock_tick), .interp_tick(interp_tick),
        .alignment_request_pin(alignment_request_pin),
        .lock_indicator(lock_indicator), .settle_busy(settle_busy),
        .alignment_pulse(alignment_pulse), .irq(irq)
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Strobes never coincide, so each count below has one meaning
    always @(posedge mclk) begin
        phase           <= phase + 2'h1;
        pd_quarter_tick <= (phase == 2'h0);
        sm_clock_tick   <= (phase == 2'h1);
        interp_tick     <= (phase == 2'h2);
        cycles          <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle; reads land in rd at the ack edge
    task automatic wb(input logic [7:0] idx, input logic wr,
                      input logic [15:0] wd);
        adr_i <= {idx, 2'b00};
        dat_i <= {16'h0000, wd};
        we_i  <= wr;
        sel_i <= 4'h3;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge mclk);
        end while (ack_o !== 1'b1);
        rd = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge mclk);
    endtask : wb

    task automatic end_sim();
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    initial begin
        reset = 1'b1;
        {we_i, cyc_i, stb_i, cal_busy, vtune_in_window, sync_start} = '0;
        {pd_quarter_tick, sm_clock_tick, interp_tick} = '0;
        {alignment_request_pin, phase, adr_i, dat_i, sel_i} = '0;
        {bad_count, compares, cycles} = '0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        foreach (rows[i]) begin
            wb(rows[i].idx, 1'b0, 16'h0000);
            check(rd, rows[i].rst);
            wb(rows[i].idx, 1'b1, rows[i].wr);
            wb(rows[i].idx, 1'b0, 16'h0000);
            check(rd, rows[i].rb);
        end
        cal_busy <= 1'b1;
        repeat (3) @(posedge mclk);
        cal_busy <= 1'b0;
        repeat (40) @(posedge mclk);
        check(16'(lock_indicator), 16'h0000);
        vtune_in_window <= 1'b1;
        repeat (3) @(posedge mclk);
        check(16'(lock_indicator), 16'h0001);
        cal_busy <= 1'b1;
        repeat (2) @(posedge mclk);
        check(16'(lock_indicator), 16'h0000);
        wb(8'h3B, 1'b1, 16'h0000);
        vtune_in_window <= 1'b0;
        cal_busy <= 1'b0;
        n = 0;
        for (int k = 0; k < 40 && lock_indicator !== 1'b1; k++) begin
            @(posedge mclk);
            if (pd_quarter_tick === 1'b1)
                n++;
        end
        check(n, 16'h0003);
        check(16'(lock_indicator), 16'h0001);
        check(16'(irq), 16'h0001);
        wb(8'h51, 1'b1, 16'h0000);
        check(16'(irq), 16'h0000);
        wb(8'h50, 1'b0, 16'h0000);
        check(rd, 16'h0003);
        wb(8'h50, 1'b1, 16'h000F);
        wb(8'h51, 1'b1, 16'h000F);
        wb(8'h50, 1'b0, 16'h0000);
        check(rd, 16'h0000);
        // Start just after a tick so the load edge carries none
        while (sm_clock_tick !== 1'b1)
            @(posedge mclk);
        sync_start <= 1'b1;
        @(posedge mclk);
        sync_start <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            if (sm_clock_tick === 1'b1 && settle_busy === 1'b1)
                n++;
        end while (settle_busy === 1'b1 && n < 20);
        check(n, 16'h0010);
        wb(8'h50, 1'b0, 16'h0000);
        check(rd, 16'h0004);
        wb(8'h50, 1'b1, 16'h000F);
        foreach (modes[i]) begin
            alignment_request_pin <= 1'b0;
            wb(8'h47, 1'b1, modes[i].ctrl);
            repeat (40) @(posedge mclk);
            alignment_request_pin <= modes[i].req;
            prev = alignment_pulse;
            n = 0;
            repeat (64) begin
                @(posedge mclk);
                if (alignment_pulse === 1'b1 && prev === 1'b0)
                    n++;
                prev = alignment_pulse;
            end
            check(n, modes[i].rises);
        end
        wb(8'h50, 1'b0, 16'h0000);
        check(rd & 16'h0008, 16'h0008);
        check(16'(irq), 16'h0001);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        check(16'(lock_indicator), 16'h0000);
        wb(8'h3B, 1'b0, 16'h0000);
        check(rd, 16'h0001);
        end_sim();
    end
endmodule : lock_detect_sync_delay_regs_tb
